//--- rtl/scan_bus_transceiver_18bit.sv
// What this block does
// R1 - latch enable high: A data passes straight through to B
// R2 - latch enable low, store clock steady: B keeps its previous value
// R3 - latch enable low: A stored on each rising store clock edge
// R4 - output enable low drives B; high floats the nine B outputs of its own section
// R5 - B-to-A direction works the same with its own controls
// R6 - two independent 9-bit sections, together one 18-bit path
// R7 - test mode suppresses normal flow; test logic owns the pin boundary
// R8 - test port activity in normal mode leaves data flow alone
// R9 - test logic samples pin data and self-tests boundary cells
// R10 - signature compression accumulates A data input values
// R11 - pseudo-random patterns driven onto the B data outputs
// R12 - test operations run only from TCK, TMS, TDI, TDO
// R13 - test logic samples on TCK rise, changes TDO on TCK fall
// R14 - powers up in Test-Logic-Reset with test logic disabled
// R15 - test-logic reset loads instruction value selecting identification
// R16 - test-logic reset sets output-enable boundary cells 47-44 to one
// R17 - each section has its own six direction controls
// R18 - in test mode pin data and enables come from boundary cells
module scan_bus_transceiver_18bit #(
  parameter logic [31:0] ID_CODE = 32'h0000_0001  // arbitrary identification value
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        arst_n_i,
  input  wire logic [xcvr_pkg::BUS_W-1:0]  a_bus_i,
  output logic      [xcvr_pkg::BUS_W-1:0]  a_bus_o,
  output logic      [xcvr_pkg::BUS_W-1:0]  a_bus_oe_o,
  input  wire logic [xcvr_pkg::BUS_W-1:0]  b_bus_i,
  output logic      [xcvr_pkg::BUS_W-1:0]  b_bus_o,
  output logic      [xcvr_pkg::BUS_W-1:0]  b_bus_oe_o,
  input  wire logic [xcvr_pkg::SECTIONS-1:0] a_to_b_output_enable_n_i,
  input  wire logic [xcvr_pkg::SECTIONS-1:0] b_to_a_output_enable_n_i,
  input  wire logic [xcvr_pkg::SECTIONS-1:0] a_to_b_latch_enable_i,
  input  wire logic [xcvr_pkg::SECTIONS-1:0] b_to_a_latch_enable_i,
  input  wire logic [xcvr_pkg::SECTIONS-1:0] a_to_b_store_clock_i,
  input  wire logic [xcvr_pkg::SECTIONS-1:0] b_to_a_store_clock_i,
  input  wire logic                        tck_i,
  input  wire logic                        tms_i,
  input  wire logic                        tdi_i,
  output logic                             tdo_o,
  output logic                             tdo_oe_o
);

  typedef struct packed {
    logic [xcvr_pkg::SYNC_W-1:0] s1;
    logic [xcvr_pkg::SYNC_W-1:0] s2;
    logic [xcvr_pkg::SYNC_W-1:0] s3;
    logic [xcvr_pkg::SYNC_W-1:0] stable;
    logic                        tck_prev;
    xcvr_pkg::tap_state_e        tap;
    logic [xcvr_pkg::IR_W-1:0]   ir_shift;
    logic [xcvr_pkg::IR_W-1:0]   ir;
    logic [xcvr_pkg::BSR_W-1:0]  bsr_shift;
    logic [xcvr_pkg::BSR_W-1:0]  bsr_upd;
    logic [xcvr_pkg::BCR_W-1:0]  bcr_shift;
    logic [xcvr_pkg::BCR_W-1:0]  bcr;
    logic [xcvr_pkg::ID_W-1:0]   id_shift;
    logic                        bypass;
    logic                        tdo;
    logic                        tdo_oe;
  } top_s;

  top_s st;
  top_s next_st;

  logic [xcvr_pkg::BUS_W-1:0] pin_a;
  logic [xcvr_pkg::BUS_W-1:0] pin_b;
  logic                       tck_rise;
  logic                       tck_fall;
  logic                       tms;
  logic                       tdi;
  logic                       test_mode;
  logic                       runt_active;

  // ==========================================================
  // helpers
  function automatic logic [17:0] lfsr18(input logic [17:0] v);
    lfsr18 = {v[16:0], v[17] ^ v[10]};
  endfunction : lfsr18

  function automatic xcvr_pkg::tap_state_e tap_next(input xcvr_pkg::tap_state_e s,
                                                    input logic m);
    case (s)
      xcvr_pkg::TLR:   tap_next = m ? xcvr_pkg::TLR   : xcvr_pkg::RTI;
      xcvr_pkg::RTI:   tap_next = m ? xcvr_pkg::SELDR : xcvr_pkg::RTI;
      xcvr_pkg::SELDR: tap_next = m ? xcvr_pkg::SELIR : xcvr_pkg::CAPDR;
      xcvr_pkg::CAPDR: tap_next = m ? xcvr_pkg::EX1DR : xcvr_pkg::SHDR;
      xcvr_pkg::SHDR:  tap_next = m ? xcvr_pkg::EX1DR : xcvr_pkg::SHDR;
      xcvr_pkg::EX1DR: tap_next = m ? xcvr_pkg::UPDR  : xcvr_pkg::PSDR;
      xcvr_pkg::PSDR:  tap_next = m ? xcvr_pkg::EX2DR : xcvr_pkg::PSDR;
      xcvr_pkg::EX2DR: tap_next = m ? xcvr_pkg::UPDR  : xcvr_pkg::SHDR;
      xcvr_pkg::UPDR:  tap_next = m ? xcvr_pkg::SELDR : xcvr_pkg::RTI;
      xcvr_pkg::SELIR: tap_next = m ? xcvr_pkg::TLR   : xcvr_pkg::CAPIR;
      xcvr_pkg::CAPIR: tap_next = m ? xcvr_pkg::EX1IR : xcvr_pkg::SHIR;
      xcvr_pkg::SHIR:  tap_next = m ? xcvr_pkg::EX1IR : xcvr_pkg::SHIR;
      xcvr_pkg::EX1IR: tap_next = m ? xcvr_pkg::UPIR  : xcvr_pkg::PSIR;
      xcvr_pkg::PSIR:  tap_next = m ? xcvr_pkg::EX2IR : xcvr_pkg::PSIR;
      xcvr_pkg::EX2IR: tap_next = m ? xcvr_pkg::UPIR  : xcvr_pkg::SHIR;
      xcvr_pkg::UPIR:  tap_next = m ? xcvr_pkg::SELDR : xcvr_pkg::RTI;
      default:         tap_next = xcvr_pkg::TLR;
    endcase
  endfunction : tap_next

  // ==========================================================
  // decoded views of the agreed pin values
  assign pin_a     = st.stable[xcvr_pkg::SY_A_LSB +: xcvr_pkg::BUS_W];
  assign pin_b     = st.stable[xcvr_pkg::SY_B_LSB +: xcvr_pkg::BUS_W];
  assign tms       = st.stable[xcvr_pkg::SY_TMS];
  assign tdi       = st.stable[xcvr_pkg::SY_TDI];
  assign tck_rise  = st.stable[xcvr_pkg::SY_TCK] & ~st.tck_prev;      // R13
  assign tck_fall  = ~st.stable[xcvr_pkg::SY_TCK] & st.tck_prev;      // R13
  // test mode only for boundary-driving instructions outside reset
  assign test_mode = (st.tap != xcvr_pkg::TLR) &&
                     (st.ir == xcvr_pkg::OP_EXTEST || st.ir == xcvr_pkg::OP_RUNT); // R7 R8
  assign runt_active = (st.ir == xcvr_pkg::OP_RUNT) && (st.tap == xcvr_pkg::RTI);

  // ==========================================================
  // synchronisers, test access port and test registers
  always_comb begin
    next_st          = st;
    // three stages; agreed value moves when stages two and three match
    next_st.s1       = {tdi_i, tms_i, tck_i, b_to_a_store_clock_i, a_to_b_store_clock_i,
                        b_to_a_latch_enable_i, a_to_b_latch_enable_i,
                        b_to_a_output_enable_n_i, a_to_b_output_enable_n_i, b_bus_i, a_bus_i};
    next_st.s2       = st.s1;
    next_st.s3       = st.s2;
    next_st.stable   = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.stable);
    next_st.tck_prev = st.stable[xcvr_pkg::SY_TCK];

    // all test sequencing advances on the test clock only
    if (tck_rise) begin                                                // R12
      next_st.tap = tap_next(st.tap, tms);
      case (st.tap)
        xcvr_pkg::TLR: begin
          next_st.ir  = xcvr_pkg::IR_RESET;                            // R15 R14
          next_st.bcr = xcvr_pkg::BCR_RESET;
          next_st.bsr_upd[xcvr_pkg::BSR_OE_LSB +: 4] = xcvr_pkg::BSR_OE_RESET; // R16
        end
        xcvr_pkg::RTI: begin
          if (runt_active && st.bcr == xcvr_pkg::BCR_PSA) begin
            next_st.bsr_shift[xcvr_pkg::BSR_A_LSB +: 18] =
              lfsr18(st.bsr_shift[xcvr_pkg::BSR_A_LSB +: 18]) ^ pin_a;  // R10
          end else if (runt_active && st.bcr == xcvr_pkg::BCR_OUTPUT_RANDOM_PATTERN) begin
            next_st.bsr_upd[xcvr_pkg::BSR_B_LSB +: 18] =
              lfsr18(st.bsr_upd[xcvr_pkg::BSR_B_LSB +: 18]);            // R11
          end
        end
        xcvr_pkg::CAPIR: next_st.ir_shift = {{(xcvr_pkg::IR_W-2){1'b0}}, 2'b01};
        xcvr_pkg::SHIR:  next_st.ir_shift = {tdi, st.ir_shift[xcvr_pkg::IR_W-1:1]};
        xcvr_pkg::UPIR:  next_st.ir = st.ir_shift;
        xcvr_pkg::CAPDR: begin
          next_st.bypass   = 1'b0;
          next_st.id_shift = ID_CODE;
          next_st.bcr_shift = st.bcr;
          if (st.ir == xcvr_pkg::OP_SAMPLE || st.ir == xcvr_pkg::OP_EXTEST) begin
            // snapshot of every bus and control pin; TCK, TMS and TDI not captured
            next_st.bsr_shift = st.stable[xcvr_pkg::BSR_W-1:0];        // R9
          end
        end
        xcvr_pkg::SHDR: begin
          next_st.bypass    = tdi;
          next_st.id_shift  = {tdi, st.id_shift[xcvr_pkg::ID_W-1:1]};
          next_st.bcr_shift = {tdi, st.bcr_shift[xcvr_pkg::BCR_W-1:1]};
          next_st.bsr_shift = {tdi, st.bsr_shift[xcvr_pkg::BSR_W-1:1]}; // R9
        end
        xcvr_pkg::UPDR: begin
          if (st.ir == xcvr_pkg::OP_BCR) begin
            next_st.bcr = st.bcr_shift;
          end else if (st.ir == xcvr_pkg::OP_SAMPLE || st.ir == xcvr_pkg::OP_EXTEST ||
                       st.ir == xcvr_pkg::OP_RUNT) begin
            next_st.bsr_upd = st.bsr_shift;
          end
        end
        default: begin
        end
      endcase
    end

    // serial output moves on the falling test clock
    if (tck_fall) begin                                                // R13
      next_st.tdo_oe = (st.tap == xcvr_pkg::SHDR) || (st.tap == xcvr_pkg::SHIR);
      if (st.tap == xcvr_pkg::SHIR) begin
        next_st.tdo = st.ir_shift[0];
      end else if (st.ir == xcvr_pkg::OP_IDCODE) begin
        next_st.tdo = st.id_shift[0];
      end else if (st.ir == xcvr_pkg::OP_BCR) begin
        next_st.tdo = st.bcr_shift[0];
      end else if (st.ir == xcvr_pkg::OP_SAMPLE || st.ir == xcvr_pkg::OP_EXTEST ||
                   st.ir == xcvr_pkg::OP_RUNT) begin
        next_st.tdo = st.bsr_shift[0];
      end else begin
        next_st.tdo = st.bypass;
      end
    end
  end

  // state register; test port starts in its reset state
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st           <= '0;
      st.tap       <= xcvr_pkg::TLR;                                   // R14
      st.ir        <= xcvr_pkg::IR_RESET;                              // R15
      st.bcr       <= xcvr_pkg::BCR_RESET;
      st.bsr_upd[xcvr_pkg::BSR_OE_LSB +: 4] <= xcvr_pkg::BSR_OE_RESET;  // R16
      {st.s1, st.s2, st.s3, st.stable} <= {4{xcvr_pkg::SYNC_IDLE}};  // pulled-up pins idle high
    end else begin
      st <= next_st;
    end
  end

  assign tdo_o    = st.tdo;
  assign tdo_oe_o = st.tdo_oe;

  // ==========================================================
  // two independent sections
  for (genvar g = 0; g < xcvr_pkg::SECTIONS; g++) begin : g_sec     // R6
    localparam int LO = g * xcvr_pkg::SECTION_W;
    xcvr_section u_sec (
      .clk_sys_i      (clk_sys_i),
      .arst_n_i       (arst_n_i),
      .a_in_i         (pin_a[LO +: xcvr_pkg::SECTION_W]),
      .b_in_i         (pin_b[LO +: xcvr_pkg::SECTION_W]),
      .ab_oe_n_i      (st.stable[xcvr_pkg::SY_OE_LSB + g]),                  // R17
      .ba_oe_n_i      (st.stable[xcvr_pkg::SY_OE_LSB + xcvr_pkg::SECTIONS + g]),
      .ab_le_i        (st.stable[xcvr_pkg::SY_LE_LSB + g]),
      .ba_le_i        (st.stable[xcvr_pkg::SY_LE_LSB + xcvr_pkg::SECTIONS + g]),
      .ab_clk_i       (st.stable[xcvr_pkg::SY_CLK_LSB + g]),
      .ba_clk_i       (st.stable[xcvr_pkg::SY_CLK_LSB + xcvr_pkg::SECTIONS + g]),
      .test_mode_i    (test_mode),
      .test_a_i       (st.bsr_upd[xcvr_pkg::BSR_A_LSB + LO +: xcvr_pkg::SECTION_W]),
      .test_b_i       (st.bsr_upd[xcvr_pkg::BSR_B_LSB + LO +: xcvr_pkg::SECTION_W]),
      .test_ab_oe_n_i (st.bsr_upd[xcvr_pkg::BSR_OE_LSB + g]),
      .test_ba_oe_n_i (st.bsr_upd[xcvr_pkg::BSR_OE_LSB + xcvr_pkg::SECTIONS + g]),
      .a_o            (a_bus_o[LO +: xcvr_pkg::SECTION_W]),
      .a_oe_o         (a_bus_oe_o[LO +: xcvr_pkg::SECTION_W]),
      .b_o            (b_bus_o[LO +: xcvr_pkg::SECTION_W]),
      .b_oe_o         (b_bus_oe_o[LO +: xcvr_pkg::SECTION_W])
    );
  end

endmodule : scan_bus_transceiver_18bit

//--- rtl/xcvr_pkg.sv
package xcvr_pkg;

  // ==========================================================
  // widths and organisation
  localparam int SECTION_W = 9;
  localparam int SECTIONS  = 2;
  localparam int BUS_W     = SECTION_W * SECTIONS;
  localparam int CTRL_W    = 2 * SECTIONS;            // one bit per direction per section
  localparam int SYNC_W    = 2 * BUS_W + 3 * CTRL_W + 3;

  // ==========================================================
  // synchroniser vector layout
  localparam int SY_A_LSB    = 0;
  localparam int SY_B_LSB    = 18;
  localparam int SY_OE_LSB   = 36;
  localparam int SY_LE_LSB   = 40;
  localparam int SY_CLK_LSB  = 44;
  localparam int SY_TCK      = 48;
  localparam int SY_TMS      = 49;
  localparam int SY_TDI      = 50;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 51'h6_00F0_0000_0000;  // tms, tdi, enables high

  // ==========================================================
  // instruction register
  localparam int           IR_W       = 8;
  localparam logic [7:0]   IR_RESET   = 8'h81;
  localparam logic [7:0]   OP_EXTEST  = 8'h00;
  localparam logic [7:0]   OP_IDCODE  = 8'h81;
  localparam logic [7:0]   OP_SAMPLE  = 8'h82;
  localparam logic [7:0]   OP_BCR     = 8'h84;
  localparam logic [7:0]   OP_RUNT    = 8'h0A;
  localparam logic [7:0]   OP_BYPASS  = 8'hFF;

  // ==========================================================
  // boundary-scan register layout
  localparam int           BSR_W       = 48;
  localparam int           BSR_A_LSB   = 0;
  localparam int           BSR_B_LSB   = 18;
  localparam int           BSR_LE_LSB  = 36;
  localparam int           BSR_CLK_LSB = 40;
  localparam int           BSR_OE_LSB  = 44;
  localparam logic [3:0]   BSR_OE_RESET = 4'hF;

  // ==========================================================
  // boundary-control register
  localparam int           BCR_W     = 3;
  localparam logic [2:0]   BCR_RESET = 3'h2;
  localparam logic [2:0]   BCR_PSA   = 3'h2;
  localparam logic [2:0]   BCR_OUTPUT_RANDOM_PATTERN  = 3'h3;

  localparam int           ID_W      = 32;

  // ==========================================================
  // test access port controller states
  typedef enum logic [3:0] {
    TLR   = 4'b0000, RTI   = 4'b0001, SELDR = 4'b0010, CAPDR = 4'b0011,
    SHDR  = 4'b0100, EX1DR = 4'b0101, PSDR  = 4'b0110, EX2DR = 4'b0111,
    UPDR  = 4'b1000, SELIR = 4'b1001, CAPIR = 4'b1010, SHIR  = 4'b1011,
    EX1IR = 4'b1100, PSIR  = 4'b1101, EX2IR = 4'b1110, UPIR  = 4'b1111
  } tap_state_e;

endpackage : xcvr_pkg

//--- rtl/xcvr_section.sv
module xcvr_section (
  input  wire logic                           clk_sys_i,
  input  wire logic                           arst_n_i,
  input  wire logic [xcvr_pkg::SECTION_W-1:0] a_in_i,
  input  wire logic [xcvr_pkg::SECTION_W-1:0] b_in_i,
  input  wire logic                           ab_oe_n_i,
  input  wire logic                           ba_oe_n_i,
  input  wire logic                           ab_le_i,
  input  wire logic                           ba_le_i,
  input  wire logic                           ab_clk_i,
  input  wire logic                           ba_clk_i,
  input  wire logic                           test_mode_i,
  input  wire logic [xcvr_pkg::SECTION_W-1:0] test_a_i,
  input  wire logic [xcvr_pkg::SECTION_W-1:0] test_b_i,
  input  wire logic                           test_ab_oe_n_i,
  input  wire logic                           test_ba_oe_n_i,
  output logic      [xcvr_pkg::SECTION_W-1:0] a_o,
  output logic      [xcvr_pkg::SECTION_W-1:0] a_oe_o,
  output logic      [xcvr_pkg::SECTION_W-1:0] b_o,
  output logic      [xcvr_pkg::SECTION_W-1:0] b_oe_o
);

  typedef struct packed {
    logic [xcvr_pkg::SECTION_W-1:0] ab_q;
    logic [xcvr_pkg::SECTION_W-1:0] ba_q;
    logic                           ab_clk_prev;
    logic                           ba_clk_prev;
    logic [xcvr_pkg::SECTION_W-1:0] a_out;
    logic [xcvr_pkg::SECTION_W-1:0] a_oe;
    logic [xcvr_pkg::SECTION_W-1:0] b_out;
    logic [xcvr_pkg::SECTION_W-1:0] b_oe;
  } sec_s;

  sec_s st;
  sec_s next_st;

  // ==========================================================
  // latch / flip-flop path per direction and output mux
  always_comb begin
    next_st             = st;
    next_st.ab_clk_prev = ab_clk_i;
    next_st.ba_clk_prev = ba_clk_i;
    if (ab_le_i) begin
      next_st.ab_q = a_in_i;                                     // R1
    end else if (ab_clk_i && !st.ab_clk_prev) begin
      next_st.ab_q = a_in_i;                                     // R3
    end                                                          // R2
    if (ba_le_i) begin
      next_st.ba_q = b_in_i;                                     // R5
    end else if (ba_clk_i && !st.ba_clk_prev) begin
      next_st.ba_q = b_in_i;                                     // R5
    end
    if (test_mode_i) begin
      // boundary cells own the pins
      next_st.b_out = test_b_i;                                  // R18
      next_st.a_out = test_a_i;                                  // R18
      next_st.b_oe  = {xcvr_pkg::SECTION_W{~test_ab_oe_n_i}};    // R7
      next_st.a_oe  = {xcvr_pkg::SECTION_W{~test_ba_oe_n_i}};    // R7
    end else begin
      next_st.b_out = next_st.ab_q;
      next_st.a_out = next_st.ba_q;
      next_st.b_oe  = {xcvr_pkg::SECTION_W{~ab_oe_n_i}};         // R4
      next_st.a_oe  = {xcvr_pkg::SECTION_W{~ba_oe_n_i}};         // R5
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign a_o    = st.a_out;
  assign a_oe_o = st.a_oe;
  assign b_o    = st.b_out;
  assign b_oe_o = st.b_oe;

endmodule : xcvr_section

//--- test/bus_partner.sv
// =====
// far-side system logic on the A and B buses
module bus_partner (
  input  wire logic [17:0] a_drv_i,
  input  wire logic [17:0] b_drv_i,
  input  wire logic [17:0] a_dut_i,
  input  wire logic [17:0] a_oe_i,
  input  wire logic [17:0] b_dut_i,
  input  wire logic [17:0] b_oe_i,
  output logic      [17:0] a_wire_o,
  output logic      [17:0] b_wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // partner lets go of every bit the block drives
  assign a_wire_o = (a_oe_i & a_dut_i) | (~a_oe_i & a_drv_i);
  assign b_wire_o = (b_oe_i & b_dut_i) | (~b_oe_i & b_drv_i);
endmodule : bus_partner

//--- test/scan_bus_transceiver_18bit_monitor.sv
module scan_bus_transceiver_18bit_monitor (
  input wire logic        clk_sys_i,
  input wire logic        arst_n_i,
  input wire logic [17:0] a_bus_i,
  input wire logic [17:0] b_bus_i,
  input wire logic [17:0] a_bus_o,
  input wire logic [17:0] a_bus_oe_o,
  input wire logic [17:0] b_bus_o,
  input wire logic [17:0] b_bus_oe_o,
  input wire logic [1:0]  a_to_b_output_enable_n_i,
  input wire logic [1:0]  b_to_a_output_enable_n_i,
  input wire logic [1:0]  a_to_b_latch_enable_i,
  input wire logic [1:0]  b_to_a_latch_enable_i,
  input wire logic [1:0]  a_to_b_store_clock_i,
  input wire logic        tck_i,
  input wire logic        tms_i,
  input wire logic        tdo_o,
  input wire logic        tdo_oe_o
);
  // =====
  // test port rest tracking
  logic       tck_q;
  logic [2:0] ones;
  logic       tlr;
  logic [3:0] age;
  logic       q;
  // five tms-high tck rises mean test logic reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tck_q <= 1'b1;
      ones  <= 3'h0;
      tlr   <= 1'b1;
      age   <= 4'h0;
    end else begin
      tck_q <= tck_i;
      if (tck_i && !tck_q) begin
        if (!tms_i) begin
          ones <= 3'h0;
          tlr  <= 1'b0;
        end else if (ones < 3'h4) begin
          ones <= ones + 3'h1;
        end else begin
          tlr <= 1'b1;
        end
      end
      age <= !tlr ? 4'h0 : ((age == 4'hF) ? age : age + 4'h1);
    end
  end
  assign q = tlr && (age == 4'hF);  // settled in normal mode

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  // =====
  // properties
  sequence s_idle_ab;
    q && !a_to_b_latch_enable_i[1] && $stable(a_bus_i[17:9]) && $stable(a_to_b_store_clock_i[1]);
  endsequence
  sequence s_store_ab;
    s_idle_ab [*4] ##1 (q && !a_to_b_latch_enable_i[1] && $rose(a_to_b_store_clock_i[1])
      && $stable(a_bus_i[17:9])) ##1 s_idle_ab [*6];
  endsequence
  property p_tdo_edge;
    $changed(tdo_o) |-> !$past(tck_i, 2) && !$past(tck_i, 3);
  endproperty
  property p_tdo_oe_edge;
    $changed(tdo_oe_o) |-> !$past(tck_i, 2) && !$past(tck_i, 3);
  endproperty
  property p_tlr_quiet;
    q |-> !tdo_oe_o;
  endproperty
  property p_b_enable;
    (q && $stable(a_to_b_output_enable_n_i[0])) [*6]
      |-> b_bus_oe_o[8:0] == {9{!a_to_b_output_enable_n_i[0]}};
  endproperty
  property p_a_enable;
    (q && $stable(b_to_a_output_enable_n_i[1])) [*6]
      |-> a_bus_oe_o[17:9] == {9{!b_to_a_output_enable_n_i[1]}};
  endproperty
  property p_pass;
    (q && a_to_b_latch_enable_i[0] && $stable(a_bus_i[8:0])) [*6]
      |-> b_bus_o[8:0] == a_bus_i[8:0];
  endproperty
  property p_pass_ba;
    (q && b_to_a_latch_enable_i[1] && $stable(b_bus_i[17:9])) [*6]
      |-> a_bus_o[17:9] == b_bus_i[17:9];
  endproperty
  property p_hold;
    s_idle_ab [*8] |-> $stable(b_bus_o[17:9]);
  endproperty
  property p_store;
    s_store_ab |-> b_bus_o[17:9] == a_bus_i[17:9];
  endproperty
  a_tdo_edge: assert property (p_tdo_edge) else $error("tdo moved off a tck fall");
  a_tdo_oe_edge: assert property (p_tdo_oe_edge) else $error("tdo enable moved off a fall");
  a_tlr_quiet: assert property (p_tlr_quiet) else $error("tdo driven in reset state");
  a_b_enable: assert property (p_b_enable) else $error("B enable not per control");
  a_a_enable: assert property (p_a_enable) else $error("A enable not per control");
  a_pass: assert property (p_pass) else $error("B not following A");
  a_pass_ba: assert property (p_pass_ba) else $error("A not following B");
  a_hold: assert property (p_hold) else $error("latched B data moved");
  a_store: assert property (p_store) else $error("stored data not on B");
endmodule : scan_bus_transceiver_18bit_monitor

bind scan_bus_transceiver_18bit scan_bus_transceiver_18bit_monitor u_mon (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .a_bus_i(a_bus_i), .b_bus_i(b_bus_i),
  .a_bus_o(a_bus_o), .a_bus_oe_o(a_bus_oe_o), .b_bus_o(b_bus_o), .b_bus_oe_o(b_bus_oe_o),
  .a_to_b_output_enable_n_i(a_to_b_output_enable_n_i),
  .b_to_a_output_enable_n_i(b_to_a_output_enable_n_i),
  .a_to_b_latch_enable_i(a_to_b_latch_enable_i), .b_to_a_latch_enable_i(b_to_a_latch_enable_i),
  .a_to_b_store_clock_i(a_to_b_store_clock_i), .tck_i(tck_i), .tms_i(tms_i),
  .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o));

//--- test/scan_bus_transceiver_18bit_test.sv
module scan_bus_transceiver_18bit_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID_VAL = 32'h5A3C_0F01;  // arbitrary identification value
  logic        clk_sys_i, arst_n_i, tck, tms, tdi, tdo, tdo_oe;
  logic [17:0] a_wire, b_wire, a_drv, b_drv, a_o, a_oe, b_o, b_oe;
  logic [1:0]  ab_oe_n, ba_oe_n, ab_le, ba_le, ab_clk, ba_clk;
  logic [47:0] dout;
  logic        soe;
  int          n_errors, total_checks;

  // =====
  // clock, partner and block
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  bus_partner u_partner (.a_drv_i(a_drv), .b_drv_i(b_drv), .a_dut_i(a_o), .a_oe_i(a_oe),
    .b_dut_i(b_o), .b_oe_i(b_oe), .a_wire_o(a_wire), .b_wire_o(b_wire));
  scan_bus_transceiver_18bit #(.ID_CODE(ID_VAL)) DUT (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .a_bus_i(a_wire), .a_bus_o(a_o), .a_bus_oe_o(a_oe), .b_bus_i(b_wire),
    .b_bus_o(b_o), .b_bus_oe_o(b_oe), .a_to_b_output_enable_n_i(ab_oe_n),
    .b_to_a_output_enable_n_i(ba_oe_n), .a_to_b_latch_enable_i(ab_le),
    .b_to_a_latch_enable_i(ba_le), .a_to_b_store_clock_i(ab_clk), .b_to_a_store_clock_i(ba_clk),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe));

  // =====
  // shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : cyc
  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask : chk
  task automatic tck_step(input logic ms, input logic di, output logic d, output logic o);
    @(posedge clk_sys_i);
    tck <= 1'b0;
    tms <= ms;
    tdi <= di;
    cyc(8);
    d = tdo;
    o = tdo_oe;
    @(posedge clk_sys_i);
    tck <= 1'b1;
    cyc(8);
  endtask : tck_step
  // one register scan from run-test idle back to it, LSB first
  task automatic scan(input logic ir, input int n, input logic [47:0] din);
    logic d, o;
    soe = 1'b1;
    dout = '0;
    tck_step(1'b1, 1'b0, d, o);
    if (ir) tck_step(1'b1, 1'b0, d, o);
    tck_step(1'b0, 1'b0, d, o);
    tck_step(1'b0, 1'b0, d, o);
    for (int i = 0; i < n; i++) begin
      tck_step(i == n - 1, din[i], d, o);
      dout[i] = d;
      soe &= o;
    end
    tck_step(1'b1, 1'b0, d, o);
    tck_step(1'b0, 1'b0, d, o);
  endtask : scan
  task automatic tap_move(input logic ms, input int n);
    logic d, o;
    repeat (n) tck_step(ms, 1'b0, d, o);
    cyc(20);
  endtask : tap_move
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // =====
  // scenarios
  task automatic t_idcode();
    @(posedge clk_sys_i);
    a_drv   <= 18'h2B3C5;
    ab_le   <= 2'b11;
    ab_oe_n <= 2'b00;
    tap_move(1'b0, 1);
    scan(1'b0, 32, 48'h0);
    chk("id", {16'h0, ID_VAL}, dout);
    chk("tdo_oe_shift", 48'h1, soe);
    chk("b_during_scan", 48'h2B3C5, b_o);
    chk("b_oe_during_scan", 48'h3FFFF, b_oe);
  endtask : t_idcode
  task automatic t_extest();
    scan(1'b1, 8, xcvr_pkg::OP_EXTEST);
    cyc(10);
    chk("b_oe_test_reset", 48'h0, b_oe);
    scan(1'b0, 48, {4'h0, 8'h00, 18'h15A6C, 18'h0A593});
    cyc(10);
    chk("a_test_drive", 48'h0A593, a_o);
    chk("b_test_drive", 48'h15A6C, b_o);
    chk("a_oe_test", 48'h3FFFF, a_oe);
    tap_move(1'b1, 5);
    chk("b_back_normal", 48'h2B3C5, b_o);
    chk("a_oe_back_normal", 48'h0, a_oe);
  endtask : t_extest
  task automatic t_sample();
    tap_move(1'b0, 1);
    scan(1'b1, 8, xcvr_pkg::OP_SAMPLE);
    scan(1'b0, 48, {4'hF, 44'h0});
    chk("sample_a", 48'h2B3C5, dout[17:0]);
    chk("sample_b", 48'h2B3C5, dout[35:18]);
    tap_move(1'b1, 5);
  endtask : t_sample
  function automatic logic [17:0] lfsr_ref(input logic [17:0] v);
    lfsr_ref = {v[16:0], v[17] ^ v[10]};
  endfunction : lfsr_ref
  // signature of a steady A bus over four idle-state test clocks
  task automatic t_psa();
    logic [17:0] sig;
    sig = '0;
    tap_move(1'b0, 1);
    scan(1'b1, 8, xcvr_pkg::OP_RUNT);
    tap_move(1'b0, 3);
    scan(1'b0, 18, 48'h3C000);
    repeat (4) sig = lfsr_ref(sig) ^ 18'h2B3C5;
    chk("signature", {30'h0, sig}, dout);
    tap_move(1'b1, 5);
  endtask : t_psa
  task automatic t_flow();
    @(posedge clk_sys_i);
    a_drv <= 18'h0;
    cyc(10);
    @(posedge clk_sys_i);
    ab_le <= 2'b01;
    cyc(10);
    @(posedge clk_sys_i);
    a_drv <= 18'h3FE01;
    cyc(10);
    chk("b_split", 48'h00001, b_o);
    @(posedge clk_sys_i);
    ab_clk <= 2'b10;
    cyc(10);
    chk("b_stored", 48'h3FE01, b_o);
    @(posedge clk_sys_i);
    a_drv <= 18'h0A5F0;
    cyc(10);
    chk("b_latched", 48'h3FFF0, b_o);
    @(posedge clk_sys_i);
    ab_oe_n <= 2'b10;
    cyc(10);
    chk("b_oe_section", 48'h001FF, b_oe);
  endtask : t_flow
  task automatic t_ba();
    @(posedge clk_sys_i);
    ab_oe_n <= 2'b11;
    ba_le   <= 2'b11;
    ba_oe_n <= 2'b00;
    b_drv   <= 18'h1D2E7;
    cyc(10);
    chk("a_pass", 48'h1D2E7, a_o);
    chk("a_oe", 48'h3FFFF, a_oe);
    @(posedge clk_sys_i);
    ba_le <= 2'b00;
    b_drv <= 18'h2C3A1;
    cyc(10);
    chk("a_latched", 48'h1D2E7, a_o);
    @(posedge clk_sys_i);
    ba_clk <= 2'b11;
    cyc(10);
    chk("a_stored", 48'h2C3A1, a_o);
  endtask : t_ba

  // =====
  // main sequence
  initial begin
    {arst_n_i, a_drv, b_drv, ab_le, ba_le, ab_clk, ba_clk, tdi} = '0;
    {ab_oe_n, ba_oe_n, tck, tms} = 6'h3F;
    n_errors = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    cyc(20);
    chk("tdo_oe_reset", 48'h0, tdo_oe);
    chk("b_oe_float", 48'h0, b_oe);
    t_idcode();
    t_extest();
    t_sample();
    t_psa();
    t_flow();
    t_ba();
    print_verdict();
  end
endmodule : scan_bus_transceiver_18bit_test
